// ### bench/tiw_src_model.sv
// Model of the external interrupt source and the timer input pin.
`timescale 1ns/100ps
module tiw_src_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq_hold,
    input  wire logic pin_run,
    output logic      ext_irq_n,
    output logic      timer_pin
);
    logic [1:0] phase_reg;

    // The line has a pull-up, so a released source reads high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_n <= 1'b1;
        end else begin
            ext_irq_n <= !irq_hold;
        end
    end

    // The pin rests low between bursts; a burst of 4N cycles gives N falling edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 2'h0;
            timer_pin <= 1'b0;
        end else if (pin_run) begin
            phase_reg <= phase_reg + 2'h1;
            timer_pin <= phase_reg[1] ^ phase_reg[0];
        end else begin
            phase_reg <= 2'h0;
            timer_pin <= 1'b0;
        end
    end
endmodule // tiw_src_model

// ### bench/tiw_unit_chk.sv
// Checker of the timer wake unit port behaviour, with its bind.
`timescale 1ns/100ps
module tiw_unit_chk #(
    parameter int CYC_DIV = 5
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        int_take,
    input wire logic [15:0] int_vector,
    input wire logic        address_strobe,
    input wire logic        data_strobe,
    input wire logic        read_write,
    input wire logic        bus_oe_n,
    input wire logic        core_halted,
    input wire logic        osc_run
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic swi_wr;
    assign swi_wr = psel && penable && pwrite && pready && paddr == tiw_pkg::TIW_CPU_OFS
                    && pwdata[tiw_pkg::TIW_CPU_SWI_BIT];

    property p_rw; read_write; endproperty
    a_rw: assert property (p_rw)
        else $error("direction line went low");
    property p_halt_pins;
        core_halted && $past(core_halted) |-> !address_strobe && !data_strobe && bus_oe_n;
    endproperty
    a_halt_pins: assert property (p_halt_pins)
        else $error("pins not parked while halted");
    property p_stop_osc; !osc_run |-> core_halted; endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("oscillator off while core runs");
    property p_vec_set; int_vector[12:4] == 9'h1FF && int_vector[0] == 1'b0; endproperty
    a_vec_set: assert property (p_vec_set)
        else $error("vector outside the vector area");
    property p_vec_on_take; !$stable(int_vector) |-> $past(int_take); endproperty
    a_vec_on_take: assert property (p_vec_on_take)
        else $error("vector changed without an accepted interrupt");
    property p_strobe_pulse; address_strobe |=> !address_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("address strobe longer than one cycle");
    property p_swi; swi_wr |-> ##[1:40] int_vector == tiw_pkg::TIW_VEC_SWI; endproperty
    a_swi: assert property (p_swi)
        else $error("software interrupt not vectored");
    property p_stop_exit;
        $fell(core_halted) && !$past(osc_run) |-> ##[0:2] int_vector == tiw_pkg::TIW_VEC_EXT;
    endproperty
    a_stop_exit: assert property (p_stop_exit)
        else $error("stop left without external interrupt");
endmodule // tiw_unit_chk

bind tiw_unit tiw_unit_chk #(.CYC_DIV(CYC_DIV)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .int_take(int_take),
    .int_vector(int_vector), .address_strobe(address_strobe), .data_strobe(data_strobe),
    .read_write(read_write), .bus_oe_n(bus_oe_n), .core_halted(core_halted),
    .osc_run(osc_run)
);

// ### bench/tiw_unit_tb.sv
// Self-checking testbench of the timer wake unit.
`timescale 1ns/100ps
module tiw_unit_tb;
    localparam logic [11:0] A_CTL = tiw_pkg::TIW_CTRL_OFS;
    localparam logic [11:0] A_CNT = tiw_pkg::TIW_COUNT_OFS;
    localparam logic [11:0] A_CPU = tiw_pkg::TIW_CPU_OFS;
    localparam logic [11:0] A_VEC = tiw_pkg::TIW_VEC_OFS;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        ext_irq_n, timer_pin, instr_done, int_take, irq_hold, pin_run, ev;
    logic [15:0] int_vector;
    logic        address_strobe, data_strobe, read_write, bus_oe_n, core_halted, osc_run;
    logic [2:0]  ph = 3'h0;
    int          miscompares = 0;
    int          check_count = 0;
    int          take_cnt = 0;
    int          n;

    tiw_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_n(ext_irq_n), .timer_pin(timer_pin),
        .instr_done(instr_done), .int_take(int_take), .int_vector(int_vector),
        .address_strobe(address_strobe), .data_strobe(data_strobe),
        .read_write(read_write), .bus_oe_n(bus_oe_n), .core_halted(core_halted),
        .osc_run(osc_run));
    tiw_src_model i_src (.pclk(pclk), .presetn(presetn), .irq_hold(irq_hold),
        .pin_run(pin_run), .ext_irq_n(ext_irq_n), .timer_pin(timer_pin));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // The core model ends an instruction every fifth clock.
    always @(posedge pclk) begin
        ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
        instr_done <= (ph == 3'h4);
        if (int_take === 1'b1) take_cnt <= take_cnt + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                        input int lim);
        for (int i = 0; i < lim; i++) begin
            apb(1'b0, a, 32'h0);
            if ((rv & m) === x) break;
        end
        chk(rv & m, x);
    endtask
    task automatic done(input string name);
        $display("test %s ended", name);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        print_verdict;
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; irq_hold = 1'b0; pin_run = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        poll(A_CNT, 32'hFFFFFFFF, 32'hF0, 1);
        poll(A_CTL, 32'hC8, 32'h40, 1);
        poll(A_VEC, 32'hFFFFFFFF, {16'h0, tiw_pkg::TIW_VEC_RESET}, 1);
        poll(A_CPU, 32'h1, 32'h1, 1);
        apb(1'b0, 12'hFF0, 32'h0);
        chk({ev, rv[30:0]}, 32'h80000000);
        done("reset");
        // Slowest tap: no step for 640 clocks after the prescaler clear.
        wr(A_CTL, 32'h4F);
        poll(A_CTL, 32'hFFFFFFFF, 32'h47, 1);
        wr(A_CNT, 32'h05);
        repeat (300) @(posedge pclk);
        poll(A_CNT, 32'hFF, 32'h05, 1);
        poll(A_CNT, 32'hFF, 32'h04, 200);
        for (int i = 0; i < 2; i++) begin
            wr(A_CTL, i ? 32'h60 : 32'h50);
            wr(A_CNT, 32'h40);
            repeat (100) @(posedge pclk);
            poll(A_CNT, 32'hFF, 32'h40, 1);
        end
        wr(A_CTL, 32'h78);
        wr(A_CNT, 32'h20);
        @(posedge pclk);
        pin_run <= 1'b1;
        repeat (12) @(posedge pclk);
        pin_run <= 1'b0;
        poll(A_CNT, 32'hFF, 32'h1D, 10);
        done("prescaler and input modes");
        wr(A_CPU, 32'h0);
        wr(A_CTL, 32'h08);
        wr(A_CNT, 32'h02);
        poll(A_CNT, 32'hFF, 32'hFE, 30);
        poll(A_VEC, 32'hFFFF, {16'h0, tiw_pkg::TIW_VEC_TIMER}, 1);
        poll(A_CPU, 32'h1, 32'h1, 1);
        poll(A_CTL, 32'h80, 32'h80, 1);
        wr(A_CTL, 32'h40);
        poll(A_CTL, 32'h80, 32'h0, 1);
        done("timer interrupt");
        @(posedge pclk);
        irq_hold <= 1'b1;
        n = take_cnt;
        wr(A_CPU, 32'h0);
        poll(A_VEC, 32'hFFFF, {16'h0, tiw_pkg::TIW_VEC_EXT}, 20);
        wr(A_CPU, 32'h0);
        for (int i = 0; i < 50 && take_cnt < n + 2; i++) @(posedge pclk);
        chk({31'h0, take_cnt >= n + 2}, 32'h1);
        irq_hold <= 1'b0;
        wr(A_CPU, 32'h0);
        repeat (20) @(posedge pclk);
        wr(A_CPU, 32'h03);
        poll(A_VEC, 32'hFFFF, {16'h0, tiw_pkg::TIW_VEC_SWI}, 20);
        done("external and software interrupts");
        wr(A_CTL, 32'hC0);
        poll(A_CTL, 32'hC0, 32'hC0, 1);
        wr(A_CPU, 32'h05);
        @(posedge pclk);
        chk({30'h0, core_halted, osc_run}, 32'h2);
        repeat (20) @(posedge pclk);
        poll(A_CTL, 32'hC0, 32'h40, 1);
        poll(A_CNT, 32'hFF, 32'hF0, 1);
        poll(A_CPU, 32'h1, 32'h0, 1);
        irq_hold <= 1'b1;
        repeat (3) @(posedge pclk);
        irq_hold <= 1'b0;
        poll(A_VEC, 32'hFFFF, {16'h0, tiw_pkg::TIW_VEC_EXT}, 30);
        chk({31'h0, core_halted}, 32'h0);
        done("stop");
        wr(A_CTL, 32'h08);
        wr(A_CNT, 32'h06);
        wr(A_CPU, 32'h09);
        @(posedge pclk);
        chk({30'h0, core_halted, osc_run}, 32'h3);
        poll(A_VEC, 32'hFFFF, {16'h0, tiw_pkg::TIW_VEC_TWAIT}, 40);
        poll(A_CTL, 32'h80, 32'h80, 1);
        done("wait");
        print_verdict;
    end
endmodule // tiw_unit_tb

// ### design/tiw_counter.sv
// Eight bit down counter with preset and one to zero detection.
`timescale 1ns/100ps
module tiw_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             step,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             preset,
    output logic      [WIDTH-1:0] count,
    output logic                  reach_zero
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= WIDTH'(tiw_pkg::TIW_COUNT_RST);
        end else if (preset) begin
            count_reg <= WIDTH'(tiw_pkg::TIW_COUNT_RST);
        end else if (load) begin
            count_reg <= load_value;
        end else if (step) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign count      = count_reg;
    assign reach_zero = step && !load && !preset && (count_reg == WIDTH'(1));
endmodule // tiw_counter

// ### design/tiw_pkg.sv
// Package with register map, field positions, reset values and vectors of the timer wake unit.
package tiw_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] TIW_CTRL_OFS    = 12'h000;
    localparam logic [11:0] TIW_COUNT_OFS   = 12'h004;
    localparam logic [11:0] TIW_CPU_OFS     = 12'h008;
    localparam logic [11:0] TIW_VEC_OFS     = 12'h00C;

    // ****************************************
    // Timer control fields
    // ****************************************
    localparam int TIW_REQ_BIT   = 7;
    localparam int TIW_MASK_BIT  = 6;
    localparam int TIW_SRC_BIT   = 5;
    localparam int TIW_PIN_BIT   = 4;
    localparam int TIW_PCLR_BIT  = 3;
    localparam int TIW_SEL_LSB   = 0;

    // ****************************************
    // Processor state register fields
    // ****************************************
    localparam int TIW_CPU_IMASK_BIT = 0;
    localparam int TIW_CPU_SWI_BIT   = 1;
    localparam int TIW_CPU_STOP_BIT  = 2;
    localparam int TIW_CPU_WAIT_BIT  = 3;
    localparam int TIW_CPU_DONE_BIT  = 4;
    localparam int TIW_CPU_RUN_BIT   = 5;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] TIW_COUNT_RST   = 8'hF0;
    localparam logic [2:0] TIW_SEL_RST     = 3'h0;

    // ****************************************
    // Service vectors
    // ****************************************
    localparam logic [15:0] TIW_VEC_TWAIT  = 16'h1FF6;
    localparam logic [15:0] TIW_VEC_TIMER  = 16'h1FF8;
    localparam logic [15:0] TIW_VEC_EXT    = 16'h1FFA;
    localparam logic [15:0] TIW_VEC_SWI    = 16'h1FFC;
    localparam logic [15:0] TIW_VEC_RESET  = 16'h1FFE;
    localparam logic [15:0] TIW_VEC_HIGH   = 16'hE000;

    // ****************************************
    // Instruction cycle divider
    // ****************************************
    localparam int TIW_CYC_DIV = 5;

    typedef enum logic [2:0] {
        TIW_SRC_NONE,
        TIW_SRC_RESET,
        TIW_SRC_SWI,
        TIW_SRC_EXT,
        TIW_SRC_TIMER,
        TIW_SRC_TWAIT
    } tiw_src_t;
endpackage

// ### design/tiw_prescaler.sv
// Seven stage prescaler that turns input clock pulses into counter step pulses.
`timescale 1ns/100ps
module tiw_prescaler #(
    parameter int WIDTH = 7
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [2:0] sel,
    output logic            step
);
    logic [WIDTH-1:0] div_reg;

    // The divider resets to zero and also clears on software request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else if (clear) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // A tap fires when all bits below it roll over, so tap n divides by 2**n.
    always_comb begin
        step = 1'b0;
        if (tick && !clear) begin
            if (sel == 3'h0) begin
                step = 1'b1;
            end else begin
                step = &div_reg[sel-3'h1 -: 1] && (&(div_reg | ~((WIDTH'(1) << sel) - WIDTH'(1))));
            end
        end
    end
endmodule // tiw_prescaler

// ### design/tiw_unit.sv
// Timer, prescaler, interrupt priority and low power mode logic with an APB register port.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
module tiw_unit #(
    parameter int CYC_DIV = tiw_pkg::TIW_CYC_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq_n,
    input  wire logic        timer_pin,
    input  wire logic        instr_done,
    output logic             int_take,
    output logic      [15:0] int_vector,
    output logic             address_strobe,
    output logic             data_strobe,
    output logic             read_write,
    output logic             bus_oe_n,
    output logic             core_halted,
    output logic             osc_run
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic        wr_en;
    logic        rd_en;
    logic        ctrl_wr;
    logic        cnt_wr;
    logic        cpu_wr;
    logic        addr_ok;
    logic        wait_wr;
    logic        stop_wr;
    logic        pclr_wr;

    // Every register answers at once, so the bus never sees a wait state.
    assign pready  = 1'b1;
    assign addr_ok = (paddr == tiw_pkg::TIW_CTRL_OFS) || (paddr == tiw_pkg::TIW_COUNT_OFS) ||
                     (paddr == tiw_pkg::TIW_CPU_OFS)  || (paddr == tiw_pkg::TIW_VEC_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign ctrl_wr = wr_en && (paddr == tiw_pkg::TIW_CTRL_OFS);
    assign cnt_wr  = wr_en && (paddr == tiw_pkg::TIW_COUNT_OFS);
    assign cpu_wr  = wr_en && (paddr == tiw_pkg::TIW_CPU_OFS);
    assign wait_wr = cpu_wr && pwdata[tiw_pkg::TIW_CPU_WAIT_BIT];
    assign stop_wr = cpu_wr && pwdata[tiw_pkg::TIW_CPU_STOP_BIT];
    assign pclr_wr = ctrl_wr && pwdata[tiw_pkg::TIW_PCLR_BIT];

    // ****************************************
    // Instruction cycle divider
    // ****************************************
    logic [7:0]  cyc_cnt_reg;
    logic        cyc_tick;
    logic        stop_reg;
    logic        wait_reg;

    // Stop halts the oscillator: the cycle divider is held at zero and cyc_tick stays low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt_reg <= 8'h00;
        end else if (stop_reg) begin
            cyc_cnt_reg <= 8'h00;
        end else if (cyc_cnt_reg == 8'(CYC_DIV - 1)) begin
            cyc_cnt_reg <= 8'h00;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
        end
    end
    assign cyc_tick = !stop_reg && (cyc_cnt_reg == 8'(CYC_DIV - 1));
    assign osc_run  = !stop_reg;

    // ****************************************
    // Timer control register
    // ****************************************
    logic        req_reg;
    logic        mask_reg;
    logic        src_reg;
    logic        pin_reg;
    logic [2:0]  sel_reg;
    logic        imask_reg;
    logic        reach_zero;
    logic        stop_entry;
    logic        pin_prev_reg;
    logic        tmr_tick;
    logic        step;
    logic [7:0]  count;

    // Source, pin and select bits keep their value across reset.
    always_ff @(posedge pclk) begin
        if (ctrl_wr) begin
            src_reg <= pwdata[tiw_pkg::TIW_SRC_BIT];
            pin_reg <= pwdata[tiw_pkg::TIW_PIN_BIT];
            sel_reg <= pwdata[tiw_pkg::TIW_SEL_LSB +: 3];
        end
    end

    // A zero crossing beats a software clear in the same cycle, so no request is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= 1'b0;
        end else if (stop_entry) begin
            req_reg <= 1'b0;
        end else if (reach_zero && !mask_reg) begin
            req_reg <= 1'b1;
        end else if (ctrl_wr) begin
            req_reg <= pwdata[tiw_pkg::TIW_REQ_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 1'b1;
        end else if (stop_entry) begin
            mask_reg <= 1'b1;
        end else if (ctrl_wr) begin
            mask_reg <= pwdata[tiw_pkg::TIW_MASK_BIT];
        end
    end

    // ****************************************
    // Timer input selection
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= timer_pin;
        end
    end

    // Counting on the pin's falling edge stands for the falling edge of the selected clock.
    // Pin pulses shorter than one clock are missed, since the pin is sampled by the clock.
    always_comb begin
        case ({src_reg, pin_reg})
            2'b00:   tmr_tick = cyc_tick;
            2'b01:   tmr_tick = cyc_tick && timer_pin;
            2'b11:   tmr_tick = pin_prev_reg && !timer_pin;
            default: tmr_tick = 1'b0;
        endcase
        if (stop_reg) begin
            tmr_tick = 1'b0;
        end
    end

    tiw_prescaler #(
        .WIDTH (7)
    ) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tmr_tick),
        .clear   (pclr_wr),
        .sel     (sel_reg),
        .step    (step)
    );

    tiw_counter #(
        .WIDTH (8)
    ) u_counter (
        .pclk       (pclk),
        .presetn    (presetn),
        .step       (step),
        .load       (cnt_wr),
        .load_value (pwdata[7:0]),
        .preset     (stop_entry),
        .count      (count),
        .reach_zero (reach_zero)
    );

    // ****************************************
    // Interrupt priority and low power modes
    // ****************************************
    tiw_pkg::tiw_src_t src_sel;
    logic        swi_reg;
    logic        reset_pend_reg;
    logic        ext_ok;
    logic        tmr_ok;
    logic        swi_ok;

    // A halted core executes nothing, so a software request waits until it runs again.
    assign swi_ok     = swi_reg && !core_halted;
    assign ext_ok     = !imask_reg && !ext_irq_n;
    assign tmr_ok     = !imask_reg && req_reg && !mask_reg;
    assign stop_entry = stop_wr && !stop_reg;

    always_comb begin
        src_sel = tiw_pkg::TIW_SRC_NONE;
        if (reset_pend_reg) begin
            src_sel = tiw_pkg::TIW_SRC_RESET;
        end else if (swi_ok) begin
            src_sel = tiw_pkg::TIW_SRC_SWI;
        end else if (ext_ok) begin
            src_sel = tiw_pkg::TIW_SRC_EXT;
        end else if (tmr_ok && !stop_reg) begin
            src_sel = wait_reg ? tiw_pkg::TIW_SRC_TWAIT : tiw_pkg::TIW_SRC_TIMER;
        end
    end

    // Interrupts are taken only at an instruction boundary, while the core sleeps, or at once while a reset is pending.
    assign int_take = (src_sel != tiw_pkg::TIW_SRC_NONE) &&
                      (instr_done || stop_reg || wait_reg || reset_pend_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_vector <= tiw_pkg::TIW_VEC_RESET;
        end else if (int_take) begin
            case (src_sel)
                tiw_pkg::TIW_SRC_RESET: int_vector <= tiw_pkg::TIW_VEC_RESET;
                tiw_pkg::TIW_SRC_SWI:   int_vector <= tiw_pkg::TIW_VEC_SWI;
                tiw_pkg::TIW_SRC_EXT:   int_vector <= tiw_pkg::TIW_VEC_EXT;
                tiw_pkg::TIW_SRC_TIMER: int_vector <= tiw_pkg::TIW_VEC_TIMER;
                tiw_pkg::TIW_SRC_TWAIT: int_vector <= tiw_pkg::TIW_VEC_TWAIT;
                default:                int_vector <= int_vector;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pend_reg <= 1'b1;
        end else if (int_take) begin
            reset_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swi_reg <= 1'b0;
        end else if (cpu_wr && pwdata[tiw_pkg::TIW_CPU_SWI_BIT]) begin
            swi_reg <= 1'b1;
        end else if (int_take && (src_sel == tiw_pkg::TIW_SRC_SWI)) begin
            swi_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_reg <= 1'b1;
        end else if (int_take) begin
            imask_reg <= 1'b1;
        end else if (stop_entry || wait_wr) begin
            imask_reg <= 1'b0;
        end else if (cpu_wr) begin
            imask_reg <= pwdata[tiw_pkg::TIW_CPU_IMASK_BIT];
        end
    end

    // Stop ends only on external interrupt or reset; the timer is frozen there.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_reg <= 1'b0;
        end else if (int_take) begin
            stop_reg <= 1'b0;
        end else if (stop_entry) begin
            stop_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 1'b0;
        end else if (int_take) begin
            wait_reg <= 1'b0;
        end else if (wait_wr && !stop_reg) begin
            wait_reg <= 1'b1;
        end
    end

    // ****************************************
    // Bus pin states
    // ****************************************
    assign core_halted = stop_reg || wait_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_strobe <= 1'b0;
            data_strobe    <= 1'b0;
            read_write     <= 1'b1;
            bus_oe_n       <= 1'b1;
        end else if (stop_reg || wait_reg) begin
            address_strobe <= 1'b0;
            data_strobe    <= 1'b0;
            read_write     <= 1'b1;
            bus_oe_n       <= 1'b1;
        end else begin
            address_strobe <= cyc_tick;
            data_strobe    <= !cyc_tick;
            read_write     <= 1'b1;
            bus_oe_n       <= 1'b0;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Read data is captured in the setup phase, so the access phase sees a frozen value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                tiw_pkg::TIW_CTRL_OFS:  prdata <= {24'h000000, req_reg, mask_reg, src_reg,
                                                   pin_reg, 1'b0, sel_reg};
                tiw_pkg::TIW_COUNT_OFS: prdata <= {24'h000000, count};
                tiw_pkg::TIW_CPU_OFS:   prdata <= {26'h0000000, !core_halted, 1'b0, wait_reg,
                                                   stop_reg, swi_reg, imask_reg};
                tiw_pkg::TIW_VEC_OFS:   prdata <= {16'h0000, int_vector};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // tiw_unit
